// ### logic/codeword_monitor_pkg.sv
// Purpose: constants for the e1 national bit codeword monitor
// Assumes: 8-bit register port at the printed offsets
// Notes:   channel index k equals the register bit: 4 = bit 4 national bit ... 0 = bit 8
package codeword_monitor_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int NCH    = 5;
  localparam int CW_W   = 4;
  localparam int WIN_W  = 12;

  // register offsets
  localparam logic [7:0] TS16_EXTRA_ALARM_STATUS = 8'h55;
  localparam logic [7:0] NATIONAL_BIT4_CODEWORD  = 8'h56;
  localparam logic [7:0] NATIONAL_BIT5_CODEWORD  = 8'h57;
  localparam logic [7:0] NATIONAL_BIT6_CODEWORD  = 8'h58;
  localparam logic [7:0] NATIONAL_BIT7_CODEWORD  = 8'h59;
  localparam logic [7:0] NATIONAL_BIT8_CODEWORD  = 8'h5a;
  localparam logic [7:0] SIXTH_BIT_PATTERN_FLAGS = 8'h5b;
  localparam logic [7:0] CODEWORD_IRQ_CONTROL    = 8'h5c;
  localparam logic [7:0] CODEWORD_IRQ_FLAGS      = 8'h5d;

  // field positions
  localparam int SIXTH_CH          = 2;
  localparam int ALIGN_SELECT_BIT  = 7;
  localparam int DEBOUNCE_BIT      = 6;
  localparam int SUMMARY_BIT       = 5;
  localparam int TS16_REMOTE_BIT   = 2;

  // reset values
  localparam logic [7:0]        CONTROL_RESET = 8'h00;
  localparam logic [CW_W-1:0]   CW_RESET      = 4'h0;
  localparam logic [NCH-1:0]    FLAGS_RESET   = 5'h00;
  localparam logic [2:0]        EXTRA_RESET   = 3'h0;

  // sixth bit patterns, index equals flag bit: 4 = all ones ... 0 = eight
  localparam logic [NCH-1:0][WIN_W-1:0] SIXTH_PATTERNS =
    {12'hfff, 12'heee, 12'hccc, 12'haaa, 12'h888};

  // history depth before a comparison is meaningful
  localparam logic [3:0] SLIDE_FILL = 4'hb;
  localparam logic [1:0] ALIGN_FILL = 2'h2;

endpackage

// ### logic/e1_national_bit_codeword_monitor.sv
// Purpose: receive-side e1 ts16_extra_alarm_status bit capture, national bit codewords, sixth bit patterns
// Assumes: framer strobes come from logic on core_clk; nfas strobe never coincides with a
//          sub multiframe start
// Notes:   codeword of a sub multiframe is taken at the first bit of the next one
// How it works
// - ts16 extra bits captured at multiframe start
// - remote alarm bit captured likewise, held unsynced
// - debounce updates only on two equal codewords
// - no debounce loads every sub multiframe
// - codewords frozen while crc multiframe unsynced
// - control bit 6 selects debounce
// - sliding twelve sixth bits compared to patterns
// - aligned mode compares three sixth codewords
// - five pattern flags, one per pattern
// - summary flag on any pattern match
// - change flag set when codeword register changes
// - bits 4..0 enable change flags onto irq
// - bit 5 enables summary flag onto irq
// - writing one clears a flag, zero keeps
`timescale 1ns/100ps
`default_nettype none

module e1_national_bit_codeword_monitor (
  input  wire logic                                   core_clk,
  input  wire logic                                   rst_b,
  input  wire logic                                   smf_sync,
  input  wire logic                                   smf_first_bit,
  input  wire logic [2:0]                             ts16_extra_in,
  input  wire logic                                   ts16_remote_alarm_in,
  input  wire logic                                   crc_sync,
  input  wire logic                                   submf_first_bit,
  input  wire logic                                   nfas_strobe,
  input  wire logic [codeword_monitor_pkg::NCH-1:0]   national_bits_in,
  input  wire logic [codeword_monitor_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [codeword_monitor_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                                   reg_wr,
  input  wire logic                                   reg_rd,
  output logic      [codeword_monitor_pkg::DATA_W-1:0] reg_rdata,
  output logic                                        irq
);

  localparam int NCH  = codeword_monitor_pkg::NCH;
  localparam int CW_W = codeword_monitor_pkg::CW_W;
  localparam int WW   = codeword_monitor_pkg::WIN_W;

  logic [2:0]                 extra_reg;
  logic                       remote_reg;
  logic [7:0]                 control_reg;
  logic [NCH-1:0][CW_W-1:0]   assemble_reg;
  logic [NCH-1:0][CW_W-1:0]   received_reg;
  logic [NCH-1:0][CW_W-1:0]   value_reg;
  logic [NCH-1:0]             change_reg;
  logic [NCH-1:0]             pattern_reg;
  logic                       summary_reg;
  logic [WW-1:0]              window_reg;
  logic [3:0]                 slide_count_reg;
  logic [WW-1:0]              history_reg;
  logic [1:0]                 align_count_reg;
  logic [7:0]                 rdata_reg;
  logic                       irq_reg;

  logic [NCH-1:0][CW_W-1:0]   value_next;
  logic [NCH-1:0]             value_load;
  logic [WW-1:0]              window_next;
  logic [WW-1:0]              history_next;
  logic [WW-1:0]              compare_word;
  logic                       compare_now;
  logic [NCH-1:0]             match;
  logic                       wr_pattern;
  logic                       wr_flags;
  logic                       rd_flags;
  logic [NCH-1:0]             pattern_clear;
  logic [NCH-1:0]             change_clear;
  logic                       summary_clear;
  logic                       debounce_on;
  logic                       align_sel;

  assign debounce_on = control_reg[codeword_monitor_pkg::DEBOUNCE_BIT];
  assign align_sel   = control_reg[codeword_monitor_pkg::ALIGN_SELECT_BIT];

  // ts16_extra_alarm_status bits only move on a multiframe start seen in sync
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      extra_reg  <= codeword_monitor_pkg::EXTRA_RESET;
      remote_reg <= 1'b0;
    end else if (smf_sync && smf_first_bit) begin
      extra_reg  <= ts16_extra_in;
      remote_reg <= ts16_remote_alarm_in;
    end
  end

  // national bits gathered per nfas frame, first received lands in bit 3
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      assemble_reg <= '0;
    end else if (nfas_strobe) begin
      for (int k = 0; k < NCH; k++) begin
        assemble_reg[k] <= {assemble_reg[k][CW_W-2:0], national_bits_in[k]};
      end
    end
  end

  // codeword load decision per channel
  always_comb begin
    value_next = value_reg;
    value_load = '0;
    for (int k = 0; k < NCH; k++) begin
      if (crc_sync && submf_first_bit) begin
        if (!debounce_on || assemble_reg[k] == received_reg[k]) begin
          value_next[k] = assemble_reg[k];
          value_load[k] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      received_reg <= '0;
      value_reg    <= '0;
    end else begin
      value_reg <= value_next;
      if (crc_sync && submf_first_bit) begin
        received_reg <= assemble_reg;
      end
    end
  end

  // sliding window of sixth bits and aligned history of sixth codewords
  assign window_next  = {window_reg[WW-2:0], national_bits_in[codeword_monitor_pkg::SIXTH_CH]};
  assign history_next = {history_reg[WW-CW_W-1:0], assemble_reg[codeword_monitor_pkg::SIXTH_CH]};

  always_ff @(posedge core_clk) begin
    if (!rst_b || !crc_sync) begin
      window_reg      <= '0;
      slide_count_reg <= '0;
      history_reg     <= '0;
      align_count_reg <= '0;
    end else begin
      if (nfas_strobe) begin
        window_reg <= window_next;
        if (slide_count_reg != codeword_monitor_pkg::SLIDE_FILL) begin
          slide_count_reg <= slide_count_reg + 4'h1;
        end
      end
      if (submf_first_bit) begin
        history_reg <= history_next;
        if (align_count_reg != codeword_monitor_pkg::ALIGN_FILL) begin
          align_count_reg <= align_count_reg + 2'h1;
        end
      end
    end
  end

  // a partial history after resync would give false matches, hence the fill counts
  always_comb begin
    if (align_sel) begin
      compare_word = history_next;
      compare_now  = crc_sync && submf_first_bit
                     && align_count_reg == codeword_monitor_pkg::ALIGN_FILL;
    end else begin
      compare_word = window_next;
      compare_now  = crc_sync && nfas_strobe
                     && slide_count_reg == codeword_monitor_pkg::SLIDE_FILL;
    end
    match = '0;
    for (int p = 0; p < NCH; p++) begin
      match[p] = compare_now && compare_word == codeword_monitor_pkg::SIXTH_PATTERNS[p];
    end
  end

  // register port decode
  assign wr_pattern = reg_wr && reg_addr == codeword_monitor_pkg::SIXTH_BIT_PATTERN_FLAGS;
  assign wr_flags   = reg_wr && reg_addr == codeword_monitor_pkg::CODEWORD_IRQ_FLAGS;
  assign rd_flags   = reg_rd && reg_addr == codeword_monitor_pkg::CODEWORD_IRQ_FLAGS;

  assign pattern_clear = wr_pattern ? reg_wdata[NCH-1:0] : '0;
  assign change_clear  = rd_flags ? '1 : (wr_flags ? reg_wdata[NCH-1:0] : '0);
  assign summary_clear = rd_flags || (wr_flags && reg_wdata[codeword_monitor_pkg::SUMMARY_BIT]);

  // sticky flags: a set in the clearing cycle wins
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pattern_reg <= codeword_monitor_pkg::FLAGS_RESET;
      change_reg  <= codeword_monitor_pkg::FLAGS_RESET;
      summary_reg <= 1'b0;
    end else begin
      pattern_reg <= (pattern_reg & ~pattern_clear) | match;
      change_reg  <= (change_reg & ~change_clear)
                     | (value_load & ~value_unchanged(value_next, value_reg));
      summary_reg <= (summary_reg && !summary_clear) || (|match);
    end
  end

  function automatic logic [NCH-1:0] value_unchanged(
    input logic [NCH-1:0][CW_W-1:0] a,
    input logic [NCH-1:0][CW_W-1:0] b
  );
    logic [NCH-1:0] same;
    same = '0;
    for (int k = 0; k < NCH; k++) begin
      same[k] = a[k] == b[k];
    end
    return same;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      control_reg <= codeword_monitor_pkg::CONTROL_RESET;
    end else if (reg_wr && reg_addr == codeword_monitor_pkg::CODEWORD_IRQ_CONTROL) begin
      control_reg <= reg_wdata;
    end
  end

  // irq follows the flag state one cycle later
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(change_reg & control_reg[NCH-1:0])
                 || (summary_reg && control_reg[codeword_monitor_pkg::SUMMARY_BIT]);
    end
  end

  // read data valid in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdata_reg <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        codeword_monitor_pkg::TS16_EXTRA_ALARM_STATUS:
          rdata_reg <= {4'h0, extra_reg[2], remote_reg, extra_reg[1:0]};
        codeword_monitor_pkg::NATIONAL_BIT4_CODEWORD:  rdata_reg <= {4'h0, value_reg[4]};
        codeword_monitor_pkg::NATIONAL_BIT5_CODEWORD:  rdata_reg <= {4'h0, value_reg[3]};
        codeword_monitor_pkg::NATIONAL_BIT6_CODEWORD:  rdata_reg <= {4'h0, value_reg[2]};
        codeword_monitor_pkg::NATIONAL_BIT7_CODEWORD:  rdata_reg <= {4'h0, value_reg[1]};
        codeword_monitor_pkg::NATIONAL_BIT8_CODEWORD:  rdata_reg <= {4'h0, value_reg[0]};
        codeword_monitor_pkg::SIXTH_BIT_PATTERN_FLAGS: rdata_reg <= {3'h0, pattern_reg};
        codeword_monitor_pkg::CODEWORD_IRQ_CONTROL:    rdata_reg <= control_reg;
        codeword_monitor_pkg::CODEWORD_IRQ_FLAGS:      rdata_reg <= {2'h0, summary_reg, change_reg};
        default:                                       rdata_reg <= 8'h00;
      endcase
    end else begin
      rdata_reg <= 8'h00;
    end
  end

  assign reg_rdata = rdata_reg;
  assign irq       = irq_reg;

endmodule

`default_nettype wire

// ### bench/framer_model.sv
// Purpose: receive framer stand-in driving multiframe strobes and national bits
// Assumes: tasks are entered just after a rising edge
// Notes:   sync levels are left to the bench
`timescale 1ns/100ps
`default_nettype none
module framer_model (
  input  wire logic       core_clk,
  output logic            smf_first_bit,
  output logic [2:0]      ts16_extra_in,
  output logic            ts16_remote_alarm_in,
  output logic            submf_first_bit,
  output logic            nfas_strobe,
  output logic [4:0]      national_bits_in
);
  initial begin
    smf_first_bit = 1'b0;
    ts16_extra_in = 3'h0;
    ts16_remote_alarm_in = 1'b0;
    submf_first_bit = 1'b0;
    nfas_strobe = 1'b0;
    national_bits_in = 5'h00;
  end
  // v is the register image: bit3 x0, bit2 remote alarm, bits1:0 x1 x2
  task automatic send_mf(input logic [3:0] v);
    @(posedge core_clk);
    smf_first_bit        <= 1'b1;
    ts16_extra_in        <= {v[3], v[1:0]};
    ts16_remote_alarm_in <= v[2];
    @(posedge core_clk);
    smf_first_bit <= 1'b0;
  endtask
  // four frames, first bit is codeword bit3, then the next sub multiframe start
  task automatic send_sub(input logic [4:0][3:0] cw);
    for (int j = 3; j >= 0; j--) begin
      @(posedge core_clk);
      nfas_strobe <= 1'b1;
      for (int c = 0; c < 5; c++) national_bits_in[c] <= cw[c][j];
      @(posedge core_clk);
      nfas_strobe <= 1'b0;
      // outside a strobe the bits are not a stale copy
      national_bits_in <= ~national_bits_in;
    end
    @(posedge core_clk);
    submf_first_bit <= 1'b1;
    @(posedge core_clk);
    submf_first_bit <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// ### bench/codeword_monitor_chk.sv
// Purpose: port assertions for the codeword monitor
// Assumes: read answer one cycle after the strobe, irq one edge after a flag
// Notes:   flag clears are judged only away from line events
`timescale 1ns/100ps
`default_nettype none
module codeword_monitor_chk (
  input wire logic       core_clk,
  input wire logic       rst_b,
  input wire logic       smf_sync,
  input wire logic       smf_first_bit,
  input wire logic [2:0] ts16_extra_in,
  input wire logic       ts16_remote_alarm_in,
  input wire logic       crc_sync,
  input wire logic       submf_first_bit,
  input wire logic       nfas_strobe,
  input wire logic [4:0] national_bits_in,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  logic       quiet;
  logic [3:0] ts16_ref_reg;
  assign quiet = !submf_first_bit && !nfas_strobe;
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      ts16_ref_reg <= 4'h0;
    end else if (smf_first_bit && smf_sync) begin
      ts16_ref_reg <= {ts16_extra_in[2], ts16_remote_alarm_in, ts16_extra_in[1:0]};
    end
  end
  AST_RDATA_IDLE:
    assert property (!reg_rd |=> reg_rdata == 8'h00) else $error("read data not idle");
  AST_UNMAPPED:
    assert property (reg_rd && !(reg_addr inside {[8'h55:8'h5d]}) |=> reg_rdata == 8'h00) else $error("unmapped data");
  AST_RSVD_BITS:
    assert property (reg_rd && reg_addr inside {[8'h55:8'h5a]} |=> reg_rdata[7:4] == 4'h0) else $error("reserved set");
  AST_TS16_CAPTURE:
    assert property (reg_rd && reg_addr == 8'h55 |=> reg_rdata[3:0] == $past(ts16_ref_reg)) else $error("ts16 bits");
  AST_CW_FROZEN:
    assert property (reg_rd && $past(reg_rd) && reg_addr == $past(reg_addr) && !$past(crc_sync)
      && reg_addr inside {[8'h56:8'h5a]} |=> reg_rdata == $past(reg_rdata)) else $error("codeword moved");
  AST_CTRL_READBACK:
    assert property (reg_wr && reg_addr == 8'h5c ##2 reg_rd && reg_addr == 8'h5c
      |=> reg_rdata == $past(reg_wdata, 3)) else $error("control readback");
  AST_IRQ_OFF:
    assert property (reg_wr && reg_addr == 8'h5c && reg_wdata == 8'h00 |=> ##1 !irq) else $error("irq not masked");
  AST_IRQ_CLEAR:
    assert property (reg_addr == 8'h5d && (reg_rd || reg_wr && reg_wdata[5:0] == 6'h3f) && quiet
      && $past(quiet) && $past(quiet, 2) |=> ##1 !irq) else $error("irq after clear");
endmodule
bind e1_national_bit_codeword_monitor codeword_monitor_chk chk_u (.*);
`default_nettype wire

// ### bench/tb_e1_national_bit_codeword_monitor.sv
// Purpose: self-checking bench for the codeword monitor
// Assumes: bus and framer tasks start just after a rising edge
// Notes:   random codewords avoid sixth bit patterns so the summary flag stays quiet
`timescale 1ns/100ps
`default_nettype none
module tb_e1_national_bit_codeword_monitor;
  logic            core_clk = 1'b0;
  logic            rst_b = 1'b0;
  logic            smf_sync = 1'b1;
  logic            crc_sync = 1'b1;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic [7:0]      reg_rdata, v;
  logic            irq, smf_first_bit, submf_first_bit, nfas_strobe, ts16_remote_alarm_in, deb;
  logic [2:0]      ts16_extra_in;
  logic [4:0]      national_bits_in, chg;
  logic [4:0][3:0] rx, prev, stored;
  logic [3:0]      ts;
  int              num_errors = 0;
  int              n_tests = 0;
  always #50 core_clk = ~core_clk;
  framer_model fr_u (.*);
  e1_national_bit_codeword_monitor dut_u (.*);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  // strobe held two cycles to give back-to-back reads; the first answer is compared
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
    chk($sformatf("reg %h", a), reg_rdata, exp);
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic chk_irq(input logic e);
    @(negedge core_clk);
    chk("irq", {7'h0, irq}, {7'h0, e});
    @(posedge core_clk);
  endtask
  function automatic logic [3:0] next_cw(input logic d, input logic [3:0] r, p, s);
    return (!d || r == p) ? r : s;
  endfunction
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    void'($urandom(32'h4091d809));
    repeat (12) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    rd(8'h5c, 8'h00);
    rd(8'h5e, 8'h00);
    wr(8'h56, 8'hff);
    rd(8'h56, 8'h00);
    v = 8'($urandom);
    wr(8'h5c, v);
    rd(8'h5c, v);
    ts = 4'h0;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      smf_sync <= !i[0];
      fr_u.send_mf(v[3:0]);
      if (!i[0]) ts = v[3:0];
      rd(8'h55, {4'h0, ts});
    end
    stored = '0;
    prev = '0;
    for (int i = 0; i < 13; i++) begin
      deb = 1'($urandom);
      crc_sync <= (i != 12);
      wr(8'h5c, {1'b1, deb, 6'h1f});
      for (int c = 0; c < 5; c++) rx[c] = ($urandom % 3 == 0) ? prev[c] : 4'($urandom) & {c != 2, 3'h7} | {3'h0, c == 2};
      fr_u.send_sub(rx);
      chg = '0;
      for (int c = 0; c < 5; c++) begin
        v[3:0] = (i == 12) ? stored[c] : next_cw(deb, rx[c], prev[c], stored[c]);
        chg[c] = v[3:0] != stored[c];
        stored[c] = v[3:0];
      end
      prev = rx;
      for (int c = 0; c < 5; c++) rd(8'h5a - 8'(c), {4'h0, stored[c]});
      chk_irq(|chg);
      rd(8'h5d, {3'h0, chg});
      chk_irq(1'b0);
    end
    for (int i = 0; i < 10; i++) begin
      crc_sync <= 1'b0;
      wr(8'h5c, {i[0], 7'h20});
      crc_sync <= 1'b1;
      rx[2] = codeword_monitor_pkg::SIXTH_PATTERNS[i / 2][3:0];
      repeat (3) fr_u.send_sub(rx);
      v = 8'h01 << (i / 2);
      rd(8'h5b, v);
      chk_irq(1'b1);
      wr(8'h5b, 8'h00);
      rd(8'h5b, v);
      wr(8'h5b, v);
      rd(8'h5b, 8'h00);
      wr(8'h5d, 8'h3f);
      chk_irq(1'b0);
    end
    wr(8'h5c, 8'h00);
    repeat (2) @(posedge core_clk);
    chk_irq(1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
